// ===== include/i2c_regs.svh
// Register offsets, field positions and reset values of the block.
`ifndef I2C_REGS_SVH
`define I2C_REGS_SVH

// Byte offsets on the register bus.
`define OWN_ADDR_OFFSET     8'h00
`define INT_ENABLE_OFFSET   8'h04
`define INT_STATUS_OFFSET   8'h08
`define MODE_CTRL_OFFSET    8'h24

// Reset values and the general call address.
`define OWN_ADDR_RESET      10'h000
`define INT_ENABLE_RESET    7'h00
`define TEN_BIT_RESET       1'b0
`define GENERAL_CALL_ADDR   10'h000

// Field widths and positions.
`define OWN_ADDR_BITS       10
`define SEVEN_BIT_BITS      7
`define ENABLE_BITS         7
`define EVENT_BITS          6
`define W1C_FLAGS           9
`define TEN_BIT_POS         8
`define EN_AAS_POS          6
`define ST_AD0_POS          8
`define ST_AAS_POS          9
`define ST_TRANSMIT_UNDERFLOW_N_POS         10
`define ST_RECEIVE_OVERRUN_POS       11
`define ST_BB_POS           12
`define ST_NOACK_SENT_FLAG_POS      13
`define ST_SLAVE_TX_DIRECTION_POS         14

// Positions inside the internal write-one-to-clear flag bank.
`define FB_STOP             5
`define FB_BB               6
`define FB_NOACK_SENT_FLAG          7
`define FB_SLAVE_TX_DIRECTION             8

`endif

// ===== include/i2c_pkg.sv
// Types shared by the address/interrupt register block.
`default_nettype none
package i2c_pkg;

    // Answer codes of the register bus.
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_type;

    // Register selected by a bus address.
    typedef enum logic [2:0] {
        SEL_OWN    = 3'b000,
        SEL_ENABLE = 3'b001,
        SEL_STATUS = 3'b010,
        SEL_MODE   = 3'b011,
        SEL_NONE   = 3'b100
    } reg_sel_type;

endpackage
`default_nettype wire

// ===== design/flag_bank.sv
// Bank of sticky flags, set by hardware, cleared by software or hardware.
`default_nettype none
module flag_bank #(
    parameter int WIDTH = 9
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] set,
    input  wire logic [WIDTH-1:0] sw_clr,
    input  wire logic [WIDTH-1:0] hw_clr,
    output logic      [WIDTH-1:0] flags
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // One flop per flag; a set in the clearing cycle wins so no event is lost.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    flags[i] <= 1'b0;
                end else if (ce) begin
                    if (set[i]) begin
                        flags[i] <= 1'b1;
                    end else if (sw_clr[i] || hw_clr[i]) begin
                        flags[i] <= 1'b0;
                    end
                end
            end

            flag_set_a: assert property (ce && set[i] |=> flags[i])
                else $error("Flag not set by its event.");
            flag_clear_a: assert property (
                ce && sw_clr[i] && !set[i] |=> !flags[i])
                else $error("Flag not cleared by a one write.");
        end
    endgenerate

endmodule // flag_bank
`default_nettype wire

// ===== design/addr_matcher.sv
// Compares an incoming bus address with the own slave address.
`default_nettype none
`include "i2c_regs.svh"
module addr_matcher (
    input  wire logic                       clk,
    input  wire logic                       rstn,
    input  wire logic                       ce,
    input  wire logic                       ten_bit_addressing,
    input  wire logic [`OWN_ADDR_BITS-1:0]  own_addr_field,
    input  wire logic                       addr_strobe,
    input  wire logic [`OWN_ADDR_BITS-1:0]  rx_addr,
    output logic                            match_pulse,
    output logic                            general_call_pulse
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic own_hit;
    logic gen_hit;

    // Seven-bit mode ignores the three upper bits of the own address.
    always_comb begin
        if (ten_bit_addressing) begin
            own_hit = (rx_addr == own_addr_field);
            gen_hit = (rx_addr == `GENERAL_CALL_ADDR);
        end else begin
            own_hit = (rx_addr[6:0] == own_addr_field[6:0]);
            gen_hit = (rx_addr[6:0] == 7'(`GENERAL_CALL_ADDR));
        end
    end

    // Pulses last one enabled cycle after the strobe.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            match_pulse        <= 1'b0;
            general_call_pulse <= 1'b0;
        end else if (ce) begin
            match_pulse        <= addr_strobe && (own_hit || gen_hit);
            general_call_pulse <= addr_strobe && gen_hit;
        end
    end

    seven_bit_a: assert property (ce && addr_strobe && !ten_bit_addressing
        && rx_addr[6:0] == own_addr_field[6:0] |=> match_pulse)
        else $error("Seven-bit own address not matched.");
    ten_bit_a: assert property (ce && addr_strobe && ten_bit_addressing
        && rx_addr[9:7] != own_addr_field[9:7]
        && rx_addr != `GENERAL_CALL_ADDR |=> !match_pulse)
        else $error("Ten-bit address matched on low bits only.");

endmodule // addr_matcher
`default_nettype wire

// ===== design/i2c_own_addr_irq_regs.sv
// Own address, interrupt enable and status registers behind AXI4-Lite.
//
// How it works
// - Ten-bit own address, writable, resets to zero.
// - Seven-bit mode compares only low seven bits.
// - Ten-bit mode compares all ten bits.
// - Unused upper bits read zero, ignore writes.
// - Seven enable bits, one per interrupt source.
// - Enables reset to 0; 1 allows request.
// - Status bits 5..0 flag events, enable order.
// - Writing one clears flag; zero leaves it.
// - Own or general call address sets addressed flag.
`default_nettype none
`include "i2c_regs.svh"
module i2c_own_addr_irq_regs
    import i2c_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // AXI4-Lite slave.
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Raw events from the protocol engine.
    input  wire logic [4:0]  raw_events,
    input  wire logic        start_seen,
    input  wire logic        stop_seen,
    input  wire logic        noack_sent_set,
    input  wire logic        slave_tx_set,
    input  wire logic        receive_overrun,
    input  wire logic        transmit_underflow_n,
    input  wire logic        addr_strobe,
    input  wire logic [9:0]  rx_addr,
    // Results towards the engine and the processor.
    output logic [9:0]       own_addr_field,
    output logic             ten_bit_addressing,
    output logic             addressed_as_slave,
    output logic             irq
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic [7:0]                  wr_addr;
    logic [31:0]                 wr_data;
    logic [3:0]                  wr_strb;
    logic                        do_write;
    reg_sel_type                 wr_sel;
    reg_sel_type                 rd_sel;
    logic [`ENABLE_BITS-1:0]     interrupt_enable;
    logic [`W1C_FLAGS-1:0]       flag_set;
    logic [`W1C_FLAGS-1:0]       flag_sw_clr;
    logic [`W1C_FLAGS-1:0]       flag_hw_clr;
    logic [`W1C_FLAGS-1:0]       flags;
    logic                        general_call_detected;
    logic                        match_pulse;
    logic                        general_call_pulse;
    logic [31:0]                 status_word;
    logic [31:0]                 read_word;
    logic                        pending;
    logic                        status_write;

    // Address decode shared by both directions; low two bits are ignored.
    function automatic reg_sel_type decode(input logic [7:0] a);
        reg_sel_type s;
        s = SEL_NONE;
        if (a[7:2] == 6'(`OWN_ADDR_OFFSET >> 2)) begin
            s = SEL_OWN;
        end
        if (a[7:2] == 6'(`INT_ENABLE_OFFSET >> 2)) begin
            s = SEL_ENABLE;
        end
        if (a[7:2] == 6'(`INT_STATUS_OFFSET >> 2)) begin
            s = SEL_STATUS;
        end
        if (a[7:2] == 6'(`MODE_CTRL_OFFSET >> 2)) begin
            s = SEL_MODE;
        end
        return s;
    endfunction

    // Write channel: address and data are taken independently, in any order.
    // The write happens once both are held and no response is outstanding.
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_sel   = decode(wr_addr);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            wr_addr       <= 8'h00;
            wr_data       <= 32'h0000_0000;
            wr_strb       <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR
                                                      : RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Own address; it spans byte lanes 0 and 1, upper bits are dropped.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            own_addr_field <= `OWN_ADDR_RESET;
        end else if (ce && do_write && wr_sel == SEL_OWN) begin
            if (wr_strb[0]) begin
                own_addr_field[7:0] <= wr_data[7:0];
            end
            if (wr_strb[1]) begin
                own_addr_field[9:8] <= wr_data[9:8];
            end
        end
    end

    // Enable bits; a zero blocks its source, a one lets it through.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            interrupt_enable <= `INT_ENABLE_RESET;
        end else if (ce && do_write && wr_sel == SEL_ENABLE
                     && wr_strb[0]) begin
            interrupt_enable <= wr_data[`ENABLE_BITS-1:0];
        end
    end

    // Addressing width, the one mode bit this block owns.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ten_bit_addressing <= `TEN_BIT_RESET;
        end else if (ce && do_write && wr_sel == SEL_MODE && wr_strb[1]) begin
            ten_bit_addressing <= wr_data[`TEN_BIT_POS];
        end
    end

    addr_matcher u_matcher (
        .clk                (clk),
        .rstn               (rstn),
        .ce                 (ce),
        .ten_bit_addressing (ten_bit_addressing),
        .own_addr_field     (own_addr_field),
        .addr_strobe        (addr_strobe),
        .rx_addr            (rx_addr),
        .match_pulse        (match_pulse),
        .general_call_pulse (general_call_pulse)
    );

    // Software clears only bits whose byte lane is strobed.
    assign status_write = do_write && wr_sel == SEL_STATUS;
    always_comb begin
        flag_sw_clr = '0;
        if (status_write && wr_strb[0]) begin
            flag_sw_clr[`EVENT_BITS-1:0] = wr_data[`EVENT_BITS-1:0];
        end
        if (status_write && wr_strb[1]) begin
            flag_sw_clr[`FB_BB]      = wr_data[`ST_BB_POS];
            flag_sw_clr[`FB_NOACK_SENT_FLAG] = wr_data[`ST_NOACK_SENT_FLAG_POS];
            flag_sw_clr[`FB_SLAVE_TX_DIRECTION]    = wr_data[`ST_SLAVE_TX_DIRECTION_POS];
        end
    end

    // Hardware sources: a stop frees the bus and ends the slave direction.
    assign flag_set = {slave_tx_set, noack_sent_set, start_seen, stop_seen,
                       raw_events};
    always_comb begin
        flag_hw_clr              = '0;
        flag_hw_clr[`FB_BB]      = stop_seen;
        flag_hw_clr[`FB_SLAVE_TX_DIRECTION]    = stop_seen || start_seen;
    end

    flag_bank #(
        .WIDTH (`W1C_FLAGS)
    ) u_flags (
        .clk    (clk),
        .rstn   (rstn),
        .ce     (ce),
        .set    (flag_set),
        .sw_clr (flag_sw_clr),
        .hw_clr (flag_hw_clr),
        .flags  (flags)
    );

    // Addressed and general-call flags last until the next start or stop.
    // A match in the same cycle as a stop is kept, so it cannot be lost.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            addressed_as_slave    <= 1'b0;
            general_call_detected <= 1'b0;
        end else if (ce) begin
            if (match_pulse) begin
                addressed_as_slave <= 1'b1;
            end else if (start_seen || stop_seen) begin
                addressed_as_slave <= 1'b0;
            end
            if (general_call_pulse) begin
                general_call_detected <= 1'b1;
            end else if (start_seen || stop_seen) begin
                general_call_detected <= 1'b0;
            end
        end
    end

    // Status word; unassigned positions stay zero.
    always_comb begin
        status_word                    = 32'h0000_0000;
        status_word[`EVENT_BITS-1:0]   = flags[`EVENT_BITS-1:0];
        status_word[`ST_AD0_POS]       = general_call_detected;
        status_word[`ST_AAS_POS]       = addressed_as_slave;
        status_word[`ST_TRANSMIT_UNDERFLOW_N_POS]      = transmit_underflow_n;
        status_word[`ST_RECEIVE_OVERRUN_POS]    = receive_overrun;
        status_word[`ST_BB_POS]        = flags[`FB_BB];
        status_word[`ST_NOACK_SENT_FLAG_POS]   = flags[`FB_NOACK_SENT_FLAG];
        status_word[`ST_SLAVE_TX_DIRECTION_POS]      = flags[`FB_SLAVE_TX_DIRECTION];
    end

    // Read mux; every register is zero-extended to the bus width.
    assign rd_sel = decode(s_axi_araddr);
    always_comb begin
        read_word = 32'h0000_0000;
        case (rd_sel)
            SEL_OWN: begin
                read_word[`OWN_ADDR_BITS-1:0] = own_addr_field;
            end
            SEL_ENABLE: begin
                read_word[`ENABLE_BITS-1:0] = interrupt_enable;
            end
            SEL_STATUS: begin
                read_word = status_word;
            end
            SEL_MODE: begin
                read_word[`TEN_BIT_POS] = ten_bit_addressing;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    // Read channel: one read at a time, answered on the next enabled edge.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= read_word;
                s_axi_rresp   <= (rd_sel == SEL_NONE) ? RESP_SLVERR
                                                       : RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Interrupt level; registered, so it trails the flags by one cycle.
    assign pending = |(flags[`EVENT_BITS-1:0]
                       & interrupt_enable[`EVENT_BITS-1:0])
                     || (addressed_as_slave
                         && interrupt_enable[`EN_AAS_POS]);
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= pending;
        end
    end

    // Sequences of the bus used by the checks below.
    sequence own_write_s;
        ce && do_write && wr_sel == SEL_OWN && wr_strb[1:0] == 2'b11;
    endsequence
    sequence status_read_s;
        ce && s_axi_arvalid && s_axi_arready && rd_sel == SEL_STATUS;
    endsequence
    sequence own_read_s;
        ce && s_axi_arvalid && s_axi_arready && rd_sel == SEL_OWN;
    endsequence

    own_addr_store_a: assert property (own_write_s
        |=> own_addr_field == $past(wr_data[9:0]))
        else $error("Own address not stored.");
    own_reserved_a: assert property (own_read_s
        |=> s_axi_rvalid && s_axi_rdata[31:10] == 22'h00_0000)
        else $error("Own address upper bits not zero.");
    status_reserved_a: assert property (status_read_s
        |=> s_axi_rdata[31:15] == 17'h0_0000
            && s_axi_rdata[7:6] == 2'b00)
        else $error("Status reserved bits not zero.");
    status_order_a: assert property (status_read_s
        |=> s_axi_rdata[5:0] == $past(flags[5:0]))
        else $error("Status event bits out of order.");
    enable_write_a: assert property (ce && do_write
        && wr_sel == SEL_ENABLE && wr_strb[0]
        |=> interrupt_enable == $past(wr_data[6:0]))
        else $error("Enable bits not written.");
    masked_quiet_a: assert property (ce && interrupt_enable == 7'h00
        |=> !irq)
        else $error("Interrupt raised while all sources blocked.");
    irq_raise_a: assert property (ce && flags[0] && interrupt_enable[0]
        |=> irq)
        else $error("Enabled flag did not raise interrupt.");
    aas_set_a: assert property (ce && match_pulse
        |=> addressed_as_slave)
        else $error("Address match did not set addressed flag.");
    status_clear_a: assert property (ce && status_write && wr_strb[0]
        && wr_data[0] && !raw_events[0] |=> !flags[0])
        else $error("Status flag not cleared by one.");
    write_answer_a: assert property (ce && do_write
        |=> s_axi_bvalid)
        else $error("Write not answered.");

endmodule // i2c_own_addr_irq_regs
`default_nettype wire

// ===== bench/bus_peer.sv
// Model of the far-side bus peers that raise events and send addresses.
`default_nettype none
module bus_peer (
    input  wire logic       clk,
    input  wire logic       req,
    input  wire logic [3:0] kind,
    input  wire logic [9:0] addr,
    output logic      [4:0] raw_events,
    output logic            start_seen,
    output logic            stop_seen,
    output logic            noack_sent_set,
    output logic            slave_tx_set,
    output logic            addr_strobe,
    output logic      [9:0] rx_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    // Quiet outputs at time zero.
    initial begin
        {raw_events, start_seen, stop_seen} = 7'h00;
        {noack_sent_set, slave_tx_set, addr_strobe} = 3'h0;
        rx_addr = 10'h000;
    end
    // Each request is one pulse; the address is scrambled outside its
    // strobe so that a stale value cannot match by accident.
    always @(posedge clk) begin
        raw_events <= (req && kind < 4'h5) ? 5'h01 << kind : 5'h00;
        stop_seen <= req && kind == 4'h5;
        start_seen <= req && kind == 4'h6;
        noack_sent_set <= req && kind == 4'h7;
        slave_tx_set <= req && kind == 4'h8;
        addr_strobe <= req && kind == 4'h9;
        rx_addr <= (req && kind == 4'h9) ? addr : ~rx_addr;
    end
endmodule // bus_peer
`default_nettype wire

// ===== bench/i2c_own_addr_irq_regs_tb.sv
// Self-checking bench of the own address and interrupt register block.
`default_nettype none
`include "i2c_regs.svh"
module i2c_own_addr_irq_regs_tb;
    import i2c_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rstn, ce, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, start_seen;
    logic        stop_seen, noack_sent_set, slave_tx_set, addr_strobe, req;
    logic        receive_overrun, transmit_underflow_n, ten_bit_addressing;
    logic        addressed_as_slave, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, r;
    logic [3:0]  wstrb, kind;
    logic [1:0]  bresp, rresp;
    logic [4:0]  raw_events;
    logic [9:0]  rx_addr, own_addr_field, paddr;
    logic [31:0] exp_q[$];
    int          miscompares, total_checks;

    i2c_own_addr_irq_regs uut (.clk(clk), .rstn(rstn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .raw_events(raw_events), .start_seen(start_seen),
        .stop_seen(stop_seen), .noack_sent_set(noack_sent_set),
        .slave_tx_set(slave_tx_set), .receive_overrun(receive_overrun),
        .transmit_underflow_n(transmit_underflow_n),
        .addr_strobe(addr_strobe), .rx_addr(rx_addr),
        .own_addr_field(own_addr_field),
        .ten_bit_addressing(ten_bit_addressing),
        .addressed_as_slave(addressed_as_slave), .irq(irq));

    bus_peer peer (.clk(clk), .req(req), .kind(kind), .addr(paddr),
        .raw_events(raw_events), .start_seen(start_seen),
        .stop_seen(stop_seen), .noack_sent_set(noack_sent_set),
        .slave_tx_set(slave_tx_set), .addr_strobe(addr_strobe),
        .rx_addr(rx_addr));

    // Free-running 25 MHz clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] got);
        total_checks++;
        if (got !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Write with both channels offered together; each drops once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] resp);
        logic aw_d, w_d;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_d = 1'b0;
        w_d = 1'b0;
        while (!(aw_d && w_d)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_d = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_d = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check("bresp", {30'h0, resp}, {30'h0, bresp});
    endtask

    // Read; the expected word is noted for the monitor below.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        exp_q.push_back(e);
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        check("rresp", (a == 8'h40) ? 32'h2 : 32'h0, {30'h0, rresp});
        rready <= 1'b0;
    endtask

    // Asks the peer for one event, then lets flags and irq settle.
    task automatic fire(input logic [3:0] k, input logic [9:0] a);
        @(posedge clk);
        req <= 1'b1;
        kind <= k;
        paddr <= a;
        @(posedge clk);
        req <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Sends an address, checks the addressed flag, ends with a stop.
    task automatic match(input logic [9:0] a, input logic e);
        fire(4'h9, a);
        check("addressed", {31'h0, e}, {31'h0, addressed_as_slave});
        fire(4'h5, 10'h000);
    endtask

    // Monitor: each accepted read answer meets the oldest note.
    always @(posedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            check("rdata", exp_q.pop_front(), rdata);
        end
    end

    // A hang is cut short long after the sequence should be done.
    initial begin
        #(40 * 20000);
        miscompares++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        {rstn, awvalid, wvalid, bready, arvalid, rready, req} = 7'h00;
        {awaddr, araddr, wdata, wstrb, kind, paddr} = 66'h0;
        {ce, transmit_underflow_n, receive_overrun} = 3'b110;
        void'($urandom(74487));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd(`OWN_ADDR_OFFSET, 32'h0000_0000);
        rd(`INT_ENABLE_OFFSET, 32'h0000_0000);
        rd(`INT_STATUS_OFFSET, 32'h0000_0400);
        check("irq", 32'h0, {31'h0, irq});
        wr(`OWN_ADDR_OFFSET, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        rd(`OWN_ADDR_OFFSET, 32'h0000_03FF);
        wr(`OWN_ADDR_OFFSET, 32'h0000_0000, 4'h2, RESP_OKAY);
        rd(`OWN_ADDR_OFFSET, 32'h0000_00FF);
        wr(`INT_ENABLE_OFFSET, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        rd(`INT_ENABLE_OFFSET, 32'h0000_007F);
        wr(8'h40, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        rd(8'h40, 32'h0000_0000);
        r = $urandom;
        wr(`OWN_ADDR_OFFSET, r, 4'hF, RESP_OKAY);
        check("own_addr", r & 32'h0000_03FF, {22'h0, own_addr_field});
        rd(`OWN_ADDR_OFFSET, r & 32'h0000_03FF);
        wr(`OWN_ADDR_OFFSET, 32'h0000_03A5, 4'hF, RESP_OKAY);
        match(10'h025, 1'b1);
        match(10'h3A4, 1'b0);
        match(10'h000, 1'b1);
        wr(`MODE_CTRL_OFFSET, 32'h0000_0100, 4'hF, RESP_OKAY);
        check("ten_bit", 32'h1, {31'h0, ten_bit_addressing});
        rd(`MODE_CTRL_OFFSET, 32'h0000_0100);
        match(10'h025, 1'b0);
        match(10'h1A5, 1'b0);
        match(10'h3A5, 1'b1);
        wr(`MODE_CTRL_OFFSET, 32'h0000_0000, 4'hF, RESP_OKAY);
        wr(`INT_STATUS_OFFSET, 32'h0000_703F, 4'hF, RESP_OKAY);
        rd(`INT_STATUS_OFFSET, 32'h0000_0400);
        // Each of the six event sources: masked, then enabled, then cleared.
        for (int i = 0; i < 6; i++) begin
            wr(`INT_ENABLE_OFFSET, ~(32'h1 << i), 4'hF, RESP_OKAY);
            fire(4'(i), 10'h000);
            check("irq", 32'h0, {31'h0, irq});
            wr(`INT_ENABLE_OFFSET, 32'h1 << i, 4'hF, RESP_OKAY);
            repeat (2) @(posedge clk);
            check("irq", 32'h1, {31'h0, irq});
            wr(`INT_STATUS_OFFSET, 32'h0000_0000, 4'hF, RESP_OKAY);
            rd(`INT_STATUS_OFFSET, (32'h1 << i) | 32'h400);
            wr(`INT_STATUS_OFFSET, 32'h1 << i, 4'hF, RESP_OKAY);
            rd(`INT_STATUS_OFFSET, 32'h0000_0400);
            repeat (2) @(posedge clk);
            check("irq", 32'h0, {31'h0, irq});
        end
        wr(`INT_ENABLE_OFFSET, 32'h0000_0040, 4'hF, RESP_OKAY);
        fire(4'h9, 10'h025);
        check("irq", 32'h1, {31'h0, irq});
        fire(4'h5, 10'h000);
        check("irq", 32'h0, {31'h0, irq});
        fire(4'h6, 10'h000);
        fire(4'h7, 10'h000);
        fire(4'h8, 10'h000);
        rd(`INT_STATUS_OFFSET, 32'h0000_7420);
        wr(`INT_STATUS_OFFSET, 32'h0000_7020, 4'h1, RESP_OKAY);
        rd(`INT_STATUS_OFFSET, 32'h0000_7400);
        wr(`INT_STATUS_OFFSET, 32'h0000_7000, 4'hF, RESP_OKAY);
        rd(`INT_STATUS_OFFSET, 32'h0000_0400);
        receive_overrun <= 1'b1;
        wr(`INT_STATUS_OFFSET, 32'hFFFF_8800, 4'hF, RESP_OKAY);
        rd(`INT_STATUS_OFFSET, 32'h0000_0C00);
        // An event pulse while the block is frozen must leave no flag.
        ce <= 1'b0;
        fire(4'h0, 10'h000);
        ce <= 1'b1;
        rd(`INT_STATUS_OFFSET, 32'h0000_0C00);
        print_verdict();
    end
endmodule // i2c_own_addr_irq_regs_tb
`default_nettype wire
